// *** hdl/bus_clock_gate_cell.sv ***
// glitch-free gate for the 48 MHz bus clock of the function core
`timescale 1ns/1ps
`default_nettype none
module bus_clock_gate_cell (
  // clock and enable
  input wire logic clk_i,
  input wire logic en_i,
  // gated clock and the enable as the gate holds it
  output logic gclk_o,
  output logic en_held_o
);

  logic en_lat;

  // the latch is transparent only while the clock is low, so the and
  // below can change only in the low phase and never cuts a pulse short
  always_latch begin
    if (!clk_i) begin
      en_lat <= en_i;
    end
  end

  assign gclk_o = clk_i & en_lat;
  assign en_held_o = en_lat;

endmodule : bus_clock_gate_cell
`default_nettype wire

// *** hdl/usb_clock_gate_xcvr_ctrl.sv ***
// usb cable-attach, bus clock gate and transceiver path control with apb registers
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module usb_clock_gate_xcvr_ctrl (
  // system clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic [usb_clk_link_pkg::APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // 48 MHz bus clock in and gated clock to the function core
  input wire logic clk_48_i,
  output logic core_clk_o,
  // function core side
  input wire usb_clk_link_pkg::core_tx_t core_tx_i,
  output usb_clk_link_pkg::core_rx_t core_rx_o,
  // internal data pads
  input wire logic data_plus_pad_i,
  output logic data_plus_pad_o,
  output logic data_plus_pad_oe_o,
  input wire logic data_minus_pad_i,
  output logic data_minus_pad_o,
  output logic data_minus_pad_oe_o,
  output logic data_plus_pullup_o,
  output logic data_minus_pulldown_o,
  // port 6 pins
  input wire logic [7:0] port6_i,
  output logic [7:0] port6_o,
  output logic [7:0] port6_oe_o,
  // general port logic that owns port 6 on the internal path
  input wire logic [7:0] gp_out_i,
  input wire logic [7:0] gp_oe_i,
  output logic [7:0] gp_in_o
);
  import usb_clk_link_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic path_ff;
  logic [31:0] prdata_ff;
  logic [7:0] p6_meta_ff;
  logic [7:0] p6_sync_ff;
  logic [1:0] pad_meta_ff;
  logic [1:0] pad_sync_ff;
  logic gate_meta_ff;
  logic gate_active_ff;
  logic gate_held;
  logic setup_phase;
  logic access_phase;
  logic wr_ctrl;
  logic wr_path;
  logic [31:0] nxt_rdata;
  logic [7:0] nxt_port6;
  logic [7:0] nxt_port6_oe;
  logic [7:0] port6_ff;
  logic [7:0] port6_oe_ff;
  logic [1:0] pad_out_ff;
  logic [1:0] pad_oe_ff;
  logic [1:0] pull_ff;
  core_rx_t core_rx_ff;
  core_rx_t nxt_core_rx;
  logic [1:0] nxt_pad_oe;
  logic attach;
  logic gate_on;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [APB_AW-1:0] addr,
                                   input logic [APB_AW-1:0] offs);
    reg_hit = (addr == offs);
  endfunction : reg_hit

  function automatic logic mapped(input logic [APB_AW-1:0] addr);
    mapped = reg_hit(addr, CTRL_OFFS) | reg_hit(addr, PATH_OFFS) |
             reg_hit(addr, STAT_OFFS);
  endfunction : mapped

  // zero wait states: every access phase completes on its first edge
  assign setup_phase = psel_i & ~penable_i;
  assign access_phase = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = access_phase & ~mapped(paddr_i);
  assign wr_ctrl = access_phase & pwrite_i & pstrb_i[0] & reg_hit(paddr_i, CTRL_OFFS);
  assign wr_path = access_phase & pwrite_i & pstrb_i[0] & reg_hit(paddr_i, PATH_OFFS);

  assign attach = ctrl_ff[ATTACH_BIT];
  assign gate_on = ctrl_ff[GATE_BIT];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata_i[7:0] & CTRL_WMASK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      path_ff <= PATH_RST;
    end else if (wr_path) begin
      path_ff <= pwdata_i[PATH_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup phase so prdata is a flop
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = RDATA_RST;
    if (reg_hit(paddr_i, CTRL_OFFS)) begin
      nxt_rdata[7:0] = ctrl_ff & CTRL_WMASK;
    end else if (reg_hit(paddr_i, PATH_OFFS)) begin
      nxt_rdata[PATH_BIT] = path_ff;
    end else if (reg_hit(paddr_i, STAT_OFFS)) begin
      nxt_rdata[STAT_GATE_BIT] = gate_active_ff;
      nxt_rdata[STAT_ATTACH_BIT] = attach;
      nxt_rdata[STAT_PATH_BIT] = path_ff;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_ff <= RDATA_RST;
    end else if (setup_phase && !pwrite_i) begin
      prdata_ff <= nxt_rdata;
    end
  end

  assign prdata_o = prdata_ff;

  // ----------------------------------------------------------------
  // bus clock gate
  // ----------------------------------------------------------------
  // software must close the gate before the pll stops and open it only
  // once the pll is stable; the gate itself does not watch the pll
  bus_clock_gate_cell u_gate (
    .clk_i(clk_48_i),
    .en_i(gate_on),
    .gclk_o(core_clk_o),
    .en_held_o(gate_held)
  );

  // the held enable lives on the 48 MHz side, so it is synchronised for status
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gate_meta_ff <= 1'b0;
      gate_active_ff <= 1'b0;
    end else begin
      gate_meta_ff <= gate_held;
      gate_active_ff <= gate_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      p6_meta_ff <= 8'h00;
      p6_sync_ff <= 8'h00;
      pad_meta_ff <= 2'b00;
      pad_sync_ff <= 2'b00;
    end else begin
      p6_meta_ff <= port6_i;
      p6_sync_ff <= p6_meta_ff;
      pad_meta_ff <= {data_plus_pad_i, data_minus_pad_i};
      pad_sync_ff <= pad_meta_ff;
    end
  end

  assign gp_in_o = p6_sync_ff;

  // ----------------------------------------------------------------
  // path multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_port6 = gp_out_i;
    nxt_port6_oe = gp_oe_i;
    nxt_core_rx.diff_plus = pad_sync_ff[1];
    nxt_core_rx.diff_minus = pad_sync_ff[0];
    // the on-chip receiver output is taken as the plus line
    nxt_core_rx.recv_data = pad_sync_ff[1];
    nxt_pad_oe = {2{attach & ~path_ff & ~core_tx_i.drive_enable_n}};
    if (path_ff) begin
      nxt_port6 = 8'h00;
      nxt_port6_oe = P6_XCVR_OE;
      nxt_port6[P6_PLUS_OUT] = core_tx_i.plus;
      nxt_port6[P6_MINUS_OUT] = core_tx_i.minus;
      nxt_port6[P6_OE_N_OUT] = core_tx_i.drive_enable_n;
      nxt_port6[P6_SUSP_OUT] = core_tx_i.suspend;
      nxt_port6[P6_SPEED_OUT] = P6_SPEED_FULL;
      nxt_core_rx.diff_plus = p6_sync_ff[P6_PLUS_IN];
      nxt_core_rx.diff_minus = p6_sync_ff[P6_MINUS_IN];
      nxt_core_rx.recv_data = p6_sync_ff[P6_RECV_IN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      port6_ff <= 8'h00;
      port6_oe_ff <= 8'h00;
      core_rx_ff <= '0;
    end else begin
      port6_ff <= nxt_port6;
      port6_oe_ff <= nxt_port6_oe;
      core_rx_ff <= nxt_core_rx;
    end
  end

  // ----------------------------------------------------------------
  // internal pads
  // ----------------------------------------------------------------
  // detached: no drive and no pull, so both pads are left floating and
  // the input synchronisers still sample whatever level they take
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pad_out_ff <= 2'b00;
      pad_oe_ff <= 2'b00;
      pull_ff <= 2'b00;
    end else begin
      pad_out_ff <= {core_tx_i.plus, core_tx_i.minus};
      pad_oe_ff <= nxt_pad_oe;
      pull_ff <= {2{attach}};
    end
  end

  assign port6_o = port6_ff;
  assign port6_oe_o = port6_oe_ff;
  assign core_rx_o = core_rx_ff;
  assign data_plus_pad_o = pad_out_ff[1];
  assign data_minus_pad_o = pad_out_ff[0];
  assign data_plus_pad_oe_o = pad_oe_ff[1];
  assign data_minus_pad_oe_o = pad_oe_ff[0];
  assign data_plus_pullup_o = pull_ff[1];
  assign data_minus_pulldown_o = pull_ff[0];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rsvd_read_zero: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    setup_phase && !pwrite_i && reg_hit(paddr_i, CTRL_OFFS)
      |=> prdata_o[31:2] == 30'h0000_0000 && prdata_o[1:0] == ctrl_ff[1:0])
    else $error("reserved control bits did not read as zero");

  a_rsvd_write_dropped: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    wr_ctrl |=> ctrl_ff == ($past(pwdata_i[7:0]) & 8'h03))
    else $error("write to control register kept reserved bits");

  a_detach_pads_hiz: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !attach |=> !data_plus_pad_oe_o && !data_minus_pad_oe_o &&
                !data_plus_pullup_o && !data_minus_pulldown_o)
    else $error("detached cable but pads driven or pulled");

  a_attach_pulls_on: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(attach) |=> data_plus_pullup_o && data_minus_pulldown_o)
    else $error("attached cable without pull-up and pull-down");

  a_gate_closes_soon: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $fell(gate_on) ##1 !gate_on [*2] |-> ##[1:12] !gate_active_ff)
    else $error("bus clock gate did not close after clearing");

  a_gate_no_runt: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    core_clk_o |-> clk_48_i)
    else $error("gated clock high while bus clock low");

  a_xcvr_outputs: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    path_ff |=> port6_oe_o == 8'h1F &&
      port6_o[4:1] == {$past(core_tx_i.plus), $past(core_tx_i.minus),
                       $past(core_tx_i.drive_enable_n), $past(core_tx_i.suspend)})
    else $error("transceiver outputs not on port 6");

  a_xcvr_inputs: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    path_ff && $past(path_ff) |=>
      core_rx_o == {$past(port6_i[7], 3), $past(port6_i[6], 3), $past(port6_i[5], 3)})
    else $error("transceiver inputs not routed to the core");

  a_speed_full: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    path_ff |=> port6_o[0] && port6_oe_o[0])
    else $error("speed select not driven high on external path");

  a_internal_path: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    !path_ff |=> port6_o == $past(gp_out_i) && port6_oe_o == $past(gp_oe_i))
    else $error("port 6 not returned to general use on internal path");

endmodule : usb_clock_gate_xcvr_ctrl
`default_nettype wire

// *** pkg/usb_clk_link_pkg.sv ***
// package: register map, reset values, pin positions and carriers of the usb clock/link control
`default_nettype none
package usb_clk_link_pkg;

  // ----------------------------------------------------------------
  // apb register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] CTRL_OFFS = 12'h000;
  localparam logic [11:0] PATH_OFFS = 12'h004;
  localparam logic [11:0] STAT_OFFS = 12'h008;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned GATE_BIT = 0;
  localparam int unsigned ATTACH_BIT = 1;
  localparam int unsigned PATH_BIT = 0;
  localparam int unsigned STAT_GATE_BIT = 0;
  localparam int unsigned STAT_ATTACH_BIT = 1;
  localparam int unsigned STAT_PATH_BIT = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h03;
  localparam logic PATH_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // port 6 bit positions while the external transceiver path is on
  // ----------------------------------------------------------------
  localparam int unsigned P6_PLUS_IN = 7;
  localparam int unsigned P6_MINUS_IN = 6;
  localparam int unsigned P6_RECV_IN = 5;
  localparam int unsigned P6_PLUS_OUT = 4;
  localparam int unsigned P6_MINUS_OUT = 3;
  localparam int unsigned P6_OE_N_OUT = 2;
  localparam int unsigned P6_SUSP_OUT = 1;
  localparam int unsigned P6_SPEED_OUT = 0;
  localparam logic [7:0] P6_XCVR_OE = 8'h1F;
  localparam logic P6_SPEED_FULL = 1'b1;

  // ----------------------------------------------------------------
  // carriers between this block and the function core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic plus;
    logic minus;
    logic drive_enable_n;
    logic suspend;
  } core_tx_t;

  typedef struct packed {
    logic diff_plus;
    logic diff_minus;
    logic recv_data;
  } core_rx_t;

endpackage : usb_clk_link_pkg
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench: apb access, pads, port 6 paths and bus clock gate
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import usb_clk_link_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clk48 = 1'b0;
  logic run48 = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] strb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, gclk;
  logic tgl = 1'b0;
  realtime t_up = 0.0;
  logic dp_o, dp_oe, dm_o, dm_oe, pull_up, pull_dn;
  core_tx_t ctx = '0;
  core_rx_t crx;
  logic [7:0] p6_o, p6_oe, p6_pin, gp_in;
  logic [7:0] gp_out = 8'h00;
  logic [7:0] gp_oe = 8'h00;
  logic [2:0] line = 3'b000;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_gclk = 0;
  // an undriven pad with no pull floats: model it as a changing level
  wire logic dp_pin = dp_oe ? dp_o : (pull_up ? 1'b1 : tgl);
  wire logic dm_pin = dm_oe ? dm_o : (pull_dn ? 1'b0 : tgl);

  always @(posedge sys_clk_i) tgl <= ~tgl;
  initial forever #2 sys_clk_i = ~sys_clk_i;
  initial forever #10.417 clk48 = run48 ? ~clk48 : 1'b0;
  always @(posedge gclk) begin
    n_gclk++;
    t_up = $realtime;
  end
  // a gate that switches while the bus clock is high leaves a short pulse
  always @(negedge gclk) begin
    if (t_up > 0.0) check($realtime - t_up > 10.0, 32'h0000_0001);
  end
  always @(gclk) check(gclk, clk48);

  usb_clock_gate_xcvr_ctrl i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(strb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .clk_48_i(clk48),
    .core_clk_o(gclk), .core_tx_i(ctx), .core_rx_o(crx), .data_plus_pad_i(dp_pin),
    .data_plus_pad_o(dp_o), .data_plus_pad_oe_o(dp_oe), .data_minus_pad_i(dm_pin),
    .data_minus_pad_o(dm_o), .data_minus_pad_oe_o(dm_oe),
    .data_plus_pullup_o(pull_up), .data_minus_pulldown_o(pull_dn),
    .port6_i(p6_pin), .port6_o(p6_o), .port6_oe_o(p6_oe), .gp_out_i(gp_out),
    .gp_oe_i(gp_oe), .gp_in_o(gp_in)
  );

  xcvr_model i_xcvr (
    .clk_i(sys_clk_i), .line_i(line), .drv_i(p6_o), .oe_i(p6_oe), .pin_o(p6_pin)
  );

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : wt

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    wt(12);
    rst_i <= 1'b0;
    rdchk(CTRL_OFFS, 32'h0000_0000);
    rdchk(STAT_OFFS, 32'h0000_0000);
    check({pull_up, pull_dn, dp_oe, dm_oe}, 32'h0000_0000);
    check(n_gclk, 32'h0000_0000);
    $display("test reset done");
    xfer(1'b1, CTRL_OFFS, 32'hFFFF_FFFC);
    rdchk(CTRL_OFFS, 32'h0000_0000);
    strb <= 4'h0;
    xfer(1'b1, CTRL_OFFS, 32'h0000_0003);
    strb <= 4'hF;
    rdchk(CTRL_OFFS, 32'h0000_0000);
    xfer(1'b0, 12'h0FC, 32'h0000_0000);
    check(err, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    $display("test register access done");
    // software saw cable supply and reports attach; gp bit 3 runs a pull-up
    ctx <= core_tx_t'(4'b1000);
    gp_out <= 8'h0D;
    gp_oe <= 8'h1F;
    line <= 3'b101;
    xfer(1'b1, CTRL_OFFS, 32'hFFFF_FFFE);
    rdchk(CTRL_OFFS, 32'h0000_0002);
    wt(4);
    check({pull_up, pull_dn}, 32'h0000_0003);
    check({dp_oe, dm_oe, dp_o, dm_o}, 32'h0000_000E);
    check(crx.diff_plus, 32'h0000_0001);
    check(p6_oe, 32'h0000_001F);
    check(p6_o & gp_oe, 32'h0000_000D);
    check(gp_in, 32'h0000_00AD);
    xfer(1'b1, CTRL_OFFS, 32'h0000_0000);
    wt(4);
    check({pull_up, pull_dn, dp_oe, dm_oe}, 32'h0000_0000);
    $display("test pads done");
    // attached while on the external path: the internal pads must stay quiet
    xfer(1'b1, CTRL_OFFS, 32'h0000_0002);
    xfer(1'b1, PATH_OFFS, 32'h0000_0001);
    for (int v = 0; v < 16; v++) begin
      ctx <= core_tx_t'(v[3:0]);
      line <= v[2:0];
      wt(5);
      check(p6_oe, 32'h0000_001F);
      check(p6_o[4:0], {v[3:0], 1'b1});
      check(crx, v[2:0]);
      check({dp_oe, dm_oe}, 32'h0000_0000);
    end
    rdchk(STAT_OFFS, 32'h0000_0006);
    xfer(1'b1, PATH_OFFS, 32'h0000_0000);
    wt(4);
    check(p6_oe, {24'h00_0000, gp_oe});
    $display("test transceiver path done");
    xfer(1'b1, CTRL_OFFS, 32'h0000_0001);
    wt(12);
    rdchk(STAT_OFFS, 32'h0000_0001);
    n_gclk = 0;
    wt(100);
    check(n_gclk > 15, 32'h0000_0001);
    // suspend: gate closes before the bus clock source stops
    xfer(1'b1, CTRL_OFFS, 32'h0000_0000);
    wt(12);
    rdchk(STAT_OFFS, 32'h0000_0000);
    n_gclk = 0;
    wt(50);
    check(n_gclk, 32'h0000_0000);
    run48 = 1'b0;
    n_gclk = 0;
    wt(50);
    check(n_gclk, 32'h0000_0000);
    // resume: gate reopens only once the source is stable again
    run48 = 1'b1;
    wt(50);
    xfer(1'b1, CTRL_OFFS, 32'h0000_0001);
    wt(12);
    n_gclk = 0;
    wt(100);
    check(n_gclk > 15, 32'h0000_0001);
    $display("test clock gate done");
    rst_i <= 1'b1;
    wt(3);
    rst_i <= 1'b0;
    rdchk(CTRL_OFFS, 32'h0000_0000);
    $display("test second reset done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// *** testbench/xcvr_model.sv ***
// far-side model: external full-speed transceiver on port 6
`timescale 1ns/1ps
`default_nettype none
module xcvr_model (
  // clock and line state
  input wire logic clk_i,
  input wire logic [2:0] line_i,
  // port 6 drive from the block
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  // resolved pin levels
  output logic [7:0] pin_o
);
  logic tgl = 1'b0;

  always @(posedge clk_i) begin
    tgl <= ~tgl;
  end

  // a floating pin shows a changing level so a stale value can never pass
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_o[i] = oe_i[i] ? drv_i[i] : tgl;
    end
    if (oe_i[7:5] == 3'b000) begin
      pin_o[7:5] = line_i;
    end
  end
endmodule : xcvr_model
`default_nettype wire
